// File: data_transfer_irq_and_timing_test.sv
`timescale 1ns/10ps
module data_transfer_irq_and_timing_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic awready, wready, bvalid, arready, rvalid, busy, mreq, mstart, mwe, mword, mkeep, keep_seen;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] src_req = 8'h00, flag_clr, cpu_irq, last_fl;
	logic [15:0] maddr, mwdata, mrdata;
	int error_cnt = 0, checked = 0, cyc = 0;

	always #4 clk = ~clk;

	xfc_core dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.src_req(src_req), .flag_clr(flag_clr), .cpu_irq(cpu_irq), .busy(busy),
		.mem_req(mreq), .mem_start(mstart), .mem_we(mwe), .mem_word(mword),
		.mem_keep_flag(mkeep), .mem_addr(maddr), .mem_wdata(mwdata), .mem_rdata(mrdata));

	xfc_mem_model mem (.clk(clk), .mem_req(mreq), .mem_start(mstart), .mem_we(mwe),
		.mem_word(mword), .mem_addr(maddr), .mem_wdata(mwdata), .mem_rdata(mrdata));

	// ----
	// bus and compare helpers
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge clk);
		resp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		rv = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic cd(input int j, input logic [7:0] ctl, bls, cnt, rld,
		input logic [15:0] sa, da);
		wr(12'h100 + 12'(8 * j), {rld, cnt, bls, ctl});
		wr(12'h104 + 12'(8 * j), {da, sa});
	endtask

	// pulse one source, then time the whole activation up to busy falling
	task automatic fire(input int s, input int tot, input logic [7:0] irq);
		int n;
		logic [7:0] seen;
		seen = 8'h00;
		last_fl = 8'h00;
		keep_seen = 1'b0;
		src_req <= 8'h01 << s;
		@(posedge clk);
		src_req <= 8'h00;
		n = 1;
		while (busy !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		while (busy === 1'b1 && n < 400) begin
			seen |= cpu_irq;
			last_fl |= flag_clr;
			keep_seen |= mkeep & mreq & ~mwe;
			@(posedge clk);
			n++;
		end
		seen |= cpu_irq;
		last_fl |= flag_clr;
		chk(32'(n), 32'(tot + 3));
		chk({24'h0, seen}, {24'h0, irq});
	endtask

	task automatic tally_and_finish();
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_bus();
		rd(12'h010);
		chk({30'h0, resp}, 32'h2);
		wr(12'h000, 32'h0000_00ff);
		wr(12'h008, 32'h0402_0100);
		wr(12'h00c, 32'h0706_0500);
	endtask

	task automatic t_normal();
		cd(0, 8'h00, 8'h02, 8'h01, 8'h00, 16'h1000, 16'h1010);
		fire(0, 11, 8'h01);
		chk({16'h0, mem.ram[8'h11], mem.ram[8'h10]}, 32'h0000_0100);
		chk({31'h0, keep_seen}, 32'h0000_0001);
		rd(12'h000);
		chk(rv, 32'h0000_00fe);
	endtask

	task automatic t_odd();
		cd(1, 8'h0c, 8'h03, 8'h02, 8'h00, 16'h1020, 16'h1030);
		fire(1, 15, 8'h00);
		chk({31'h0, keep_seen}, 32'h0000_0000);
		chk({8'h0, mem.ram[8'h32], mem.ram[8'h31], mem.ram[8'h30]}, 32'h0022_2120);
		rd(12'h108);
		chk(rv, 32'h0001_030c);
		rd(12'h10c);
		chk(rv, 32'h1033_1023);
	endtask

	task automatic t_chain();
		cd(2, 8'h10, 8'h02, 8'h02, 8'h00, 16'h1051, 16'h1060);
		cd(3, 8'h00, 8'h02, 8'h01, 8'h00, 16'h0070, 16'h1080);
		fire(2, 21, 8'h00);
		chk({16'h0, mem.ram[8'h81], mem.ram[8'h80]}, 32'h0000_7170);
	endtask

	task automatic t_rpt();
		cd(4, 8'h23, 8'h02, 8'h01, 8'h01, 16'h1000, 16'h1040);
		fire(3, 12, 8'h08);
		rd(12'h000);
		chk(rv, 32'h0000_00f6);
		wr(12'h000, 32'h0000_00ff);
		cd(4, 8'h03, 8'h02, 8'h01, 8'h01, 16'h1000, 16'h1040);
		fire(3, 12, 8'h00);
	endtask

	task automatic t_src();
		cd(5, 8'h00, 8'h02, 8'h01, 8'h00, 16'h1000, 16'h1090);
		fire(5, 11, 8'h00);
		cd(7, 8'h00, 8'h02, 8'h01, 8'h00, 16'h1000, 16'h10a0);
		fire(7, 11, 8'h00);
		chk({24'h0, last_fl}, 32'h0000_0080);
		rd(12'h000);
		chk(rv, 32'h0000_00ff);
		cd(6, 8'h00, 8'h02, 8'h01, 8'h00, 16'h1000, 16'h10b0);
		fire(6, 11, 8'h40);
		chk({24'h0, last_fl}, 32'h0000_0040);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_bus();
		t_normal();
		t_odd();
		t_chain();
		t_rpt();
		t_src();
		tally_and_finish();
	end
endmodule // data_transfer_irq_and_timing_test

// File: xfc_core.sv
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module xfc_core (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// activation sources and cpu side
	input wire logic [7:0] src_req,
	output logic [7:0] flag_clr,
	output logic [7:0] cpu_irq,
	output logic busy,
	// memory port
	output logic mem_req,
	output logic mem_start,
	output logic mem_we,
	output logic mem_word,
	output logic mem_keep_flag,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	xfc_pkg::xfc_state_t st_q;
	logic [3:0] cyc_q;
	logic [2:0] src_q;
	logic [4:0] set_q;
	logic [7:0] ctl_q, rem_q, act_en_q;
	logic [15:0] sar_q, dar_q;
	logic first_q, irq_dec_q, keep_q, done_q, err_q;
	logic [31:0] vec_lo_q, vec_hi_q;
	logic [31:0] cd_q [0:47];
	logic [7:0] pend_v, acc_v;
	logic gnt_ok, take;
	logic [2:0] gnt_idx;

	function automatic logic [3:0] acc_cyc(input logic [15:0] a, input logic w, input logic wr);
		logic odd;
		odd = a[0];
		if (a <= xfc_pkg::SFR_HI) begin
			acc_cyc = (w && odd) ? xfc_pkg::AC_SFR_ODD : xfc_pkg::AC_SFR;
		end else if (!wr && a >= xfc_pkg::DFL_LO && a <= xfc_pkg::DFL_HI) begin
			acc_cyc = w ? xfc_pkg::AC_DFL_W : xfc_pkg::AC_DFL_B;
		end else if (!wr && a >= xfc_pkg::ROM_LO) begin
			acc_cyc = w ? xfc_pkg::AC_ROM_W : xfc_pkg::AC_ONE;
		end else begin
			acc_cyc = (w && odd) ? xfc_pkg::AC_ODD : xfc_pkg::AC_ONE;
		end
	endfunction

	// ----------------------------------------
	// control set decode
	// ----------------------------------------
	logic [31:0] w0, w1;
	logic [7:0] c, n, cnt, rld, cnt_w, vbyte;
	logic [15:0] sa, da, sa_w, da_w;
	logic rpt, s_mv, d_mv, hit0, irq_now, wd;
	logic [3:0] wb_n;
	logic [15:0] step, n_sar, n_dar;
	logic [7:0] n_rem;

	assign w0 = cd_q[{set_q, 1'h0}];
	assign w1 = cd_q[{set_q, 1'h1}];
	assign c = w0[xfc_pkg::CD_CTL +: 8];
	assign n = w0[xfc_pkg::CD_BLS +: 8];
	assign cnt = w0[xfc_pkg::CD_CNT +: 8];
	assign rld = w0[xfc_pkg::CD_RLD +: 8];
	assign sa = w1[xfc_pkg::CD_SAR +: 16];
	assign da = w1[xfc_pkg::CD_DAR +: 16];
	assign rpt = c[xfc_pkg::C_RPT];
	// the repeat side always moves, the other side only when incrementing
	assign s_mv = c[xfc_pkg::C_SRC_INC] | (rpt & c[xfc_pkg::C_RPT_SRC]);
	assign d_mv = c[xfc_pkg::C_DST_INC] | (rpt & ~c[xfc_pkg::C_RPT_SRC]);
	assign hit0 = cnt == 8'h01;
	assign irq_now = hit0 & (~rpt | c[xfc_pkg::C_RPT_IRQ]);
	assign cnt_w = (rpt && hit0) ? rld : cnt - 8'h01;
	// repeat area restarts at its 256-byte boundary
	always_comb begin
		sa_w = s_mv ? sa + {8'h00, n} : sa;
		da_w = d_mv ? da + {8'h00, n} : da;
		if (rpt && hit0 && c[xfc_pkg::C_RPT_SRC]) begin
			sa_w = {sa[15:8], 8'h00};
		end
		if (rpt && hit0 && !c[xfc_pkg::C_RPT_SRC]) begin
			da_w = {da[15:8], 8'h00};
		end
	end
	assign wb_n = 4'h1 + {3'h0, s_mv} + {3'h0, d_mv};
	// upper four sources live in the second vector word
	assign vbyte = src_q[2] ? vec_hi_q[{src_q[1:0], 3'h0} +: 8]
		: vec_lo_q[{src_q[1:0], 3'h0} +: 8];

	// data step: words while two or more bytes remain
	assign wd = rem_q[7:1] != 7'h00;
	assign step = wd ? 16'h0002 : 16'h0001;
	assign n_sar = ctl_q[xfc_pkg::C_SRC_INC] | (ctl_q[xfc_pkg::C_RPT] & ctl_q[xfc_pkg::C_RPT_SRC])
		? sar_q + step : sar_q;
	assign n_dar = ctl_q[xfc_pkg::C_DST_INC] | (ctl_q[xfc_pkg::C_RPT] & ~ctl_q[xfc_pkg::C_RPT_SRC])
		? dar_q + step : dar_q;
	assign n_rem = rem_q - (wd ? 8'h02 : 8'h01);

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	always_comb begin
		gnt_ok = 1'h0;
		gnt_idx = 3'h0;
		for (int i = xfc_pkg::NSRC - 1; i >= 0; i--) begin
			if (pend_v[i] && act_en_q[i]) begin
				gnt_ok = 1'h1;
				gnt_idx = 3'(i);
			end
		end
	end
	assign take = st_q == xfc_pkg::S_IDLE && gnt_ok;

	// ----------------------------------------
	// activation acknowledgement per source
	// ----------------------------------------
	for (genvar g = 0; g < xfc_pkg::NSRC; g++) begin : g_ack
		logic [3:0] hold_q;
		logic pend_q, que_q, fc_q;
		// own source is refused while pending, holding or being served
		assign acc_v[g] = src_req[g] && !pend_q && hold_q == 4'h0 && !(busy && src_q == 3'(g));
		assign pend_v[g] = pend_q;
		assign flag_clr[g] = fc_q;
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				pend_q <= 1'h0;
				que_q <= 1'h0;
				hold_q <= 4'h0;
				fc_q <= 1'h0;
			end else begin
				if (acc_v[g]) begin
					pend_q <= 1'h1;
				end else if (take && gnt_idx == 3'(g)) begin
					pend_q <= 1'h0;
				end
				if (acc_v[g] && busy) begin
					que_q <= 1'h1;
				end else if (done_q) begin
					que_q <= 1'h0;
				end
				// rx and tx are re-armed by their own data access instead
				if (acc_v[g] && !xfc_pkg::HS_MASK[g]) begin
					hold_q <= xfc_pkg::HOLD_CYC;
				end else if (hold_q != 4'h0 && !que_q) begin
					hold_q <= hold_q - 4'h1;
				end
				fc_q <= xfc_pkg::FLAGCLR_MASK[g] && hold_q == 4'h1 && !que_q;
			end
		end
	end

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= xfc_pkg::S_IDLE;
			cyc_q <= 4'h0;
			src_q <= 3'h0;
			set_q <= 5'h00;
			ctl_q <= 8'h00;
			rem_q <= 8'h00;
			sar_q <= 16'h0000;
			dar_q <= 16'h0000;
			first_q <= 1'h0;
			irq_dec_q <= 1'h0;
			keep_q <= 1'h0;
			done_q <= 1'h0;
			busy <= 1'h0;
			cpu_irq <= 8'h00;
			mem_req <= 1'h0;
			mem_start <= 1'h0;
			mem_we <= 1'h0;
			mem_word <= 1'h0;
			mem_keep_flag <= 1'h0;
			mem_addr <= 16'h0000;
			mem_wdata <= 16'h0000;
		end else begin
			done_q <= 1'h0;
			cpu_irq <= 8'h00;
			mem_start <= 1'h0;
			if (cyc_q != 4'h0) begin
				cyc_q <= cyc_q - 4'h1;
			end
			unique case (st_q)
				xfc_pkg::S_IDLE: begin
					if (take) begin
						st_q <= xfc_pkg::S_VEC;
						src_q <= gnt_idx;
						busy <= 1'h1;
						first_q <= 1'h1;
						irq_dec_q <= 1'h0;
						cyc_q <= xfc_pkg::VEC_CYC - 4'h1;
					end
				end
				xfc_pkg::S_VEC: begin
					if (vbyte < xfc_pkg::NSET) begin
						set_q <= vbyte[4:0];
						st_q <= xfc_pkg::S_CDR;
						cyc_q <= xfc_pkg::CDR_CYC - 4'h1;
					end else begin
						st_q <= xfc_pkg::S_TAIL;
						cyc_q <= xfc_pkg::TAIL_CYC - 4'h1;
					end
				end
				xfc_pkg::S_CDR: begin
					if (cyc_q == 4'h0) begin
						ctl_q <= c;
						rem_q <= n;
						sar_q <= sa;
						dar_q <= da;
						if (first_q) begin
							irq_dec_q <= irq_now;
							keep_q <= irq_now;
						end else begin
							keep_q <= 1'h0;
						end
						st_q <= xfc_pkg::S_WB;
						cyc_q <= wb_n - 4'h1;
					end
				end
				xfc_pkg::S_WB: begin
					if (cyc_q == 4'h0 && rem_q != 8'h00) begin
						st_q <= xfc_pkg::S_RD;
						cyc_q <= acc_cyc(sar_q, wd, 1'h0) - 4'h1;
						mem_req <= 1'h1;
						mem_start <= 1'h1;
						mem_we <= 1'h0;
						mem_word <= wd;
						mem_addr <= sar_q;
						mem_keep_flag <= keep_q;
					end else if (cyc_q == 4'h0) begin
						first_q <= 1'h0;
						if (ctl_q[xfc_pkg::C_CHAIN] && set_q != xfc_pkg::LAST_SET) begin
							set_q <= set_q + 5'h01;
							st_q <= xfc_pkg::S_CDR;
							cyc_q <= xfc_pkg::CDR_CYC - 4'h1;
						end else begin
							st_q <= xfc_pkg::S_TAIL;
							cyc_q <= xfc_pkg::TAIL_CYC - 4'h1;
						end
					end
				end
				xfc_pkg::S_RD: begin
					if (cyc_q == 4'h0) begin
						st_q <= xfc_pkg::S_WR;
						cyc_q <= acc_cyc(dar_q, wd, 1'h1) - 4'h1;
						mem_start <= 1'h1;
						mem_we <= 1'h1;
						mem_keep_flag <= 1'h0;
						mem_addr <= dar_q;
						mem_wdata <= wd ? mem_rdata : {8'h00, mem_rdata[7:0]};
					end
				end
				xfc_pkg::S_WR: begin
					if (cyc_q == 4'h0) begin
						sar_q <= n_sar;
						dar_q <= n_dar;
						rem_q <= n_rem;
						mem_we <= 1'h0;
						if (n_rem != 8'h00) begin
							st_q <= xfc_pkg::S_RD;
							cyc_q <= acc_cyc(n_sar, n_rem[7:1] != 7'h00, 1'h0) - 4'h1;
							mem_start <= 1'h1;
							mem_word <= n_rem[7:1] != 7'h00;
							mem_addr <= n_sar;
							mem_keep_flag <= keep_q;
						end else begin
							mem_req <= 1'h0;
							first_q <= 1'h0;
							if (ctl_q[xfc_pkg::C_CHAIN] && set_q != xfc_pkg::LAST_SET) begin
								set_q <= set_q + 5'h01;
								st_q <= xfc_pkg::S_CDR;
								cyc_q <= xfc_pkg::CDR_CYC - 4'h1;
							end else begin
								st_q <= xfc_pkg::S_TAIL;
								cyc_q <= xfc_pkg::TAIL_CYC - 4'h1;
							end
						end
					end
				end
				xfc_pkg::S_TAIL: begin
					if (cyc_q == 4'h0) begin
						st_q <= xfc_pkg::S_IDLE;
						busy <= 1'h0;
						done_q <= 1'h1;
						if (irq_dec_q && !xfc_pkg::NOIRQ_MASK[src_q]) begin
							cpu_irq <= 8'h01 << src_q;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	logic [11:0] wa;
	logic [31:0] wm;
	logic wr_en, w_cd, r_cd, w_ok, r_ok;
	logic [31:0] rd_mux;

	assign wa = s_axi_awaddr;
	assign wr_en = s_axi_awready;
	assign s_axi_wready = s_axi_awready;
	assign wm = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign w_cd = wa[11:8] == xfc_pkg::A_CD_PAGE && wa[7:2] < xfc_pkg::CD_WORDS;
	assign r_cd = s_axi_araddr[11:8] == xfc_pkg::A_CD_PAGE && s_axi_araddr[7:2] < xfc_pkg::CD_WORDS;
	assign w_ok = w_cd || wa == xfc_pkg::A_ACT_EN || wa == xfc_pkg::A_STATUS
		|| wa == xfc_pkg::A_VEC_LO || wa == xfc_pkg::A_VEC_HI;

	always_comb begin
		r_ok = 1'h1;
		rd_mux = 32'h0000_0000;
		if (r_cd) begin
			rd_mux = cd_q[s_axi_araddr[7:2]];
		end else if (s_axi_araddr == xfc_pkg::A_ACT_EN) begin
			rd_mux[7:0] = act_en_q;
		end else if (s_axi_araddr == xfc_pkg::A_STATUS) begin
			rd_mux[xfc_pkg::ST_BUSY] = busy;
			rd_mux[xfc_pkg::ST_SET +: 5] = set_q;
			rd_mux[xfc_pkg::ST_ERR] = err_q;
		end else if (s_axi_araddr == xfc_pkg::A_VEC_LO) begin
			rd_mux = vec_lo_q;
		end else if (s_axi_araddr == xfc_pkg::A_VEC_HI) begin
			rd_mux = vec_hi_q;
		end else begin
			r_ok = 1'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'h0;
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= xfc_pkg::RESP_OK;
			s_axi_arready <= 1'h0;
			s_axi_rvalid <= 1'h0;
			s_axi_rresp <= xfc_pkg::RESP_OK;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
			if (wr_en) begin
				s_axi_bvalid <= 1'h1;
				s_axi_bresp <= w_ok ? xfc_pkg::RESP_OK : xfc_pkg::RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'h0;
			end
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'h1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= r_ok ? xfc_pkg::RESP_OK : xfc_pkg::RESP_ERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'h0;
			end
		end
	end

	// ----------------------------------------
	// software registers and control data
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			act_en_q <= xfc_pkg::ACT_EN_RST;
			vec_lo_q <= xfc_pkg::VEC_RST;
			vec_hi_q <= xfc_pkg::VEC_RST;
			err_q <= 1'h0;
		end else begin
			if (wr_en && wa == xfc_pkg::A_ACT_EN) begin
				act_en_q <= (act_en_q & ~wm[7:0]) | (s_axi_wdata[7:0] & wm[7:0]);
			end
			// same-edge clear by the engine overrides the software write
			if (st_q == xfc_pkg::S_TAIL && cyc_q == 4'h0 && irq_dec_q
				&& !xfc_pkg::NOIRQ_MASK[src_q]) begin
				act_en_q[src_q] <= 1'h0;
			end
			if (wr_en && wa == xfc_pkg::A_VEC_LO) begin
				vec_lo_q <= (vec_lo_q & ~wm) | (s_axi_wdata & wm);
			end
			if (wr_en && wa == xfc_pkg::A_VEC_HI) begin
				vec_hi_q <= (vec_hi_q & ~wm) | (s_axi_wdata & wm);
			end
			if (st_q == xfc_pkg::S_VEC && vbyte >= xfc_pkg::NSET) begin
				err_q <= 1'h1;
			end else if (wr_en && wa == xfc_pkg::A_STATUS && wm[xfc_pkg::ST_ERR]
				&& s_axi_wdata[xfc_pkg::ST_ERR]) begin
				err_q <= 1'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 48; i++) begin
				cd_q[i] <= 32'h0000_0000;
			end
		end else if (st_q == xfc_pkg::S_WB && cyc_q == 4'h0) begin
			cd_q[{set_q, 1'h0}] <= {rld, cnt_w, n, c};
			cd_q[{set_q, 1'h1}] <= {da_w, sa_w};
		end else if (wr_en && w_cd) begin
			cd_q[wa[7:2]] <= (cd_q[wa[7:2]] & ~wm) | (s_axi_wdata & wm);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [3:0] wb_len_q;
	always_ff @(posedge clk) begin
		wb_len_q <= st_q == xfc_pkg::S_WB ? wb_len_q + 4'h1 : 4'h0;
	end

	property p_vec_one;
		st_q == xfc_pkg::S_VEC |=> st_q inside {xfc_pkg::S_CDR, xfc_pkg::S_TAIL};
	endproperty
	a_vec_one: assert property (p_vec_one) else $error("vector read not one cycle");

	property p_cdr_five;
		st_q == xfc_pkg::S_CDR && $past(st_q) != xfc_pkg::S_CDR
			|-> (st_q == xfc_pkg::S_CDR) [*5] ##1 st_q == xfc_pkg::S_WB;
	endproperty
	a_cdr_five: assert property (p_cdr_five) else $error("control read not five cycles");

	property p_wb_norm;
		st_q == xfc_pkg::S_WB && cyc_q == 4'h0 && !ctl_q[xfc_pkg::C_RPT]
			|-> wb_len_q == {3'h0, ctl_q[xfc_pkg::C_SRC_INC]} + {3'h0, ctl_q[xfc_pkg::C_DST_INC]};
	endproperty
	a_wb_norm: assert property (p_wb_norm) else $error("normal write-back length");

	property p_wb_rpt;
		st_q == xfc_pkg::S_WB && cyc_q == 4'h0 && ctl_q[xfc_pkg::C_RPT]
			|-> wb_len_q == 4'h1 + {3'h0, ctl_q[xfc_pkg::C_RPT_SRC] ? ctl_q[xfc_pkg::C_DST_INC]
			: ctl_q[xfc_pkg::C_SRC_INC]};
	endproperty
	a_wb_rpt: assert property (p_wb_rpt) else $error("repeat write-back length");

	property p_irq_en;
		cpu_irq != 8'h00 |-> (cpu_irq & act_en_q) == 8'h00;
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("enable kept after interrupt");

	property p_no_irq;
		(cpu_irq & xfc_pkg::NOIRQ_MASK) == 8'h00;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("interrupt from silent source");

	property p_irq_cause;
		st_q == xfc_pkg::S_TAIL && cyc_q == 4'h0 && irq_dec_q && !xfc_pkg::NOIRQ_MASK[src_q]
			|=> cpu_irq == 8'h01 << src_q ##1 cpu_irq == 8'h00;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("completion interrupt missing");

	property p_hold;
		acc_v[0] |=> (!acc_v[0]) [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("generic source taken again too soon");

	property p_flash_clr;
		acc_v[7] && !busy |-> ##11 flag_clr[7];
	endproperty
	a_flash_clr: assert property (p_flash_clr) else $error("flash flag clear late");

	property p_word;
		mem_start && !mem_word |-> rem_q == 8'h01;
	endproperty
	a_word: assert property (p_word) else $error("byte access before last byte");

	c_chain: cover property (st_q == xfc_pkg::S_WR ##1 st_q == xfc_pkg::S_CDR);
	c_irq: cover property (cpu_irq != 8'h00);
	c_odd: cover property (mem_start && !mem_word && mem_we);

endmodule // xfc_core

// File: xfc_mem_model.sv
`timescale 1ns/10ps
module xfc_mem_model (
	// clock
	input wire logic clk,
	// memory port
	input wire logic mem_req,
	input wire logic mem_start,
	input wire logic mem_we,
	input wire logic mem_word,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata
);
	logic [7:0] ram [0:255];
	logic [15:0] junk_q = 16'h5a5a;

	initial begin
		for (int i = 0; i < 256; i++) begin
			ram[i] = 8'(i);
		end
	end

	// ----
	// idle bus toggles so a stale value never reads as good data
	// ----
	always @(posedge clk) begin
		junk_q <= ~junk_q;
		if (mem_req && mem_start && mem_we) begin
			ram[mem_addr[7:0]] <= mem_wdata[7:0];
			if (mem_word) begin
				ram[mem_addr[7:0] + 8'h01] <= mem_wdata[15:8];
			end
		end
	end

	assign mem_rdata = (mem_req && !mem_we) ?
		{ram[mem_addr[7:0] + 8'h01], ram[mem_addr[7:0]]} : junk_q;
endmodule // xfc_mem_model

// File: xfc_pkg.sv
package xfc_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NSRC = 8;
	localparam logic [7:0] NSET = 8'h18;
	localparam logic [4:0] LAST_SET = 5'h17;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] A_ACT_EN = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_VEC_LO = 12'h008;
	localparam logic [11:0] A_VEC_HI = 12'h00c;
	localparam logic [3:0] A_CD_PAGE = 4'h1;
	localparam logic [5:0] CD_WORDS = 6'h30;
	localparam logic [7:0] ACT_EN_RST = 8'h00;
	localparam logic [31:0] VEC_RST = 32'h0000_0000;
	localparam int ST_BUSY = 0;
	localparam int ST_SET = 8;
	localparam int ST_ERR = 16;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// ----------------------------------------
	// control data layout
	// ----------------------------------------
	localparam int CD_CTL = 0;
	localparam int CD_BLS = 8;
	localparam int CD_CNT = 16;
	localparam int CD_RLD = 24;
	localparam int CD_SAR = 0;
	localparam int CD_DAR = 16;
	localparam int C_RPT = 0;
	localparam int C_RPT_SRC = 1;
	localparam int C_SRC_INC = 2;
	localparam int C_DST_INC = 3;
	localparam int C_CHAIN = 4;
	localparam int C_RPT_IRQ = 5;

	// ----------------------------------------
	// source classes: 0-3 generic, 4 rx full, 5 tx empty, 6 timer, 7 flash
	// ----------------------------------------
	localparam logic [7:0] NOIRQ_MASK = 8'ha0;
	localparam logic [7:0] FLAGCLR_MASK = 8'hc0;
	localparam logic [7:0] HS_MASK = 8'h30;

	// ----------------------------------------
	// cycle counts
	// ----------------------------------------
	localparam logic [3:0] VEC_CYC = 4'h1;
	localparam logic [3:0] CDR_CYC = 4'h5;
	localparam logic [3:0] TAIL_CYC = 4'h2;
	localparam logic [3:0] HOLD_CYC = 4'ha;
	localparam logic [3:0] AC_ONE = 4'h1;
	localparam logic [3:0] AC_ODD = 4'h2;
	localparam logic [3:0] AC_SFR = 4'h2;
	localparam logic [3:0] AC_SFR_ODD = 4'h4;
	localparam logic [3:0] AC_DFL_B = 4'h2;
	localparam logic [3:0] AC_DFL_W = 4'h4;
	localparam logic [3:0] AC_ROM_W = 4'h2;

	// ----------------------------------------
	// memory regions
	// ----------------------------------------
	localparam logic [15:0] SFR_HI = 16'h02ff;
	localparam logic [15:0] DFL_LO = 16'h3000;
	localparam logic [15:0] DFL_HI = 16'h3fff;
	localparam logic [15:0] ROM_LO = 16'h4000;

	typedef enum logic [2:0] {S_IDLE, S_VEC, S_CDR, S_WB, S_RD, S_WR, S_TAIL} xfc_state_t;

endpackage
